// ==== rtl/watchdog_control_status.sv ====
// watchdog control register, timeout counter and protected write sequence
`timescale 1ns/1ps
module watchdog_control_status import wdog_pkg::*; #(
	parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEFAULT
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// register access from the core
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic instr_done_i,
	output logic [7:0] reg_rdata_o,
	// supply monitor interrupt
	input wire logic supply_monitor_irq_i,
	// timeout responses
	output logic wdog_reset_o,
	output logic wdog_irq_o
);
	// counter width; one spare value so the terminal count always fits
	localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1);

	// protected write sequence state
	logic write_en_reg, write_en_next;
	logic armed_reg, armed_next;

	// control and status bits
	logic enable_reg, enable_next;
	logic status_reg, status_next;
	logic irsel_reg, irsel_next;

	// timeout counter
	logic [CW-1:0] count_reg, count_next;

	// registered timeout responses
	logic reset_pulse_reg;
	logic irq_pulse_reg;

	// a write while armed is the second instruction of the sequence and is taken whole
	wire logic accepted_wr = reg_wr_i && armed_reg;

	// a write while idle can only set the write enable, nothing else is stored
	wire logic arm_wr = reg_wr_i && !armed_reg && reg_wdata_i[WRITE_EN_POS];

	// any instruction after arming ends the sequence, write or not
	wire logic seq_end = armed_reg && (instr_done_i || reg_wr_i);

	// software refresh: an accepted write with the enable bit set
	wire logic refresh = accepted_wr && reg_wdata_i[ENABLE_POS];

	// a software zero write to the status bit
	wire logic status_clr = accepted_wr && !reg_wdata_i[STATUS_POS];

	// terminal count of the running counter
	wire logic at_limit = count_reg == CW'(TIMEOUT_CYCLES - 1);

	// a refresh in the last cycle still saves the period
	wire logic expire = enable_reg && !refresh && at_limit;

	// the response select decides what a missed refresh produces
	wire logic timeout_reset = expire && !irsel_reg;
	wire logic timeout_irq = expire && irsel_reg;

	// counter restarts on refresh, while disabled and after each expiry
	wire logic count_clr = refresh || !enable_reg || expire;

	// write enable arms on its own write and lasts for exactly one more instruction
	always_comb begin
		write_en_next = write_en_reg;
		armed_next = armed_reg;
		if (arm_wr) begin
			write_en_next = 1'b1;
			armed_next = 1'b1;
		end else if (seq_end) begin
			write_en_next = 1'b0;
			armed_next = 1'b0;
		end
	end

	// response select is only changed by an accepted write
	always_comb begin
		irsel_next = irsel_reg;
		if (accepted_wr)
			irsel_next = reg_wdata_i[IRSEL_POS];
	end

	// hardware set wins over a software clear in the same cycle, so no timeout is lost
	always_comb begin
		status_next = status_reg;
		if (status_clr)
			status_next = 1'b0;
		if (expire)
			status_next = 1'b1;
	end

	// clears from a watchdog reset or the supply monitor win over a software write
	always_comb begin
		enable_next = enable_reg;
		if (accepted_wr)
			enable_next = reg_wdata_i[ENABLE_POS];
		if (timeout_reset || supply_monitor_irq_i)
			enable_next = 1'b0;
	end

	// counter next value; it stays cleared while the watchdog is off
	always_comb begin
		count_next = count_reg;
		if (count_clr)
			count_next = '0;
		else
			count_next = count_reg + CW'(1);
	end

	// write enable bit as software sees it
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			write_en_reg <= CONTROL_RESET[WRITE_EN_POS];
		else
			write_en_reg <= write_en_next;
	end

	// sequence tracker kept apart from the visible bit
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			armed_reg <= 1'b0;
		else
			armed_reg <= armed_next;
	end

	// enable bit
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			enable_reg <= CONTROL_RESET[ENABLE_POS];
		else
			enable_reg <= enable_next;
	end

	// status flag; the hardware reset and a software zero write clear it, the watchdog reset is an output event
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			status_reg <= CONTROL_RESET[STATUS_POS];
		else
			status_reg <= status_next;
	end

	// response select bit
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			irsel_reg <= CONTROL_RESET[IRSEL_POS];
		else
			irsel_reg <= irsel_next;
	end

	// timeout counter; the prescaler is outside this block, so it counts core clocks
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end

	// watchdog reset pulse, one cycle long
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			reset_pulse_reg <= 1'b0;
		else
			reset_pulse_reg <= timeout_reset;
	end

	// watchdog interrupt pulse, one cycle long
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			irq_pulse_reg <= 1'b0;
		else
			irq_pulse_reg <= timeout_irq;
	end

	// read data straight from flops; prescaler bits are outside this block and read zero
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			reg_rdata_o <= CONTROL_RESET;
		else
			reg_rdata_o <= {4'h0, irsel_next, status_next, enable_next, write_en_next};
	end

	// timeout responses leave straight from their flops
	assign wdog_reset_o = reset_pulse_reg;
	assign wdog_irq_o = irq_pulse_reg;
endmodule

// ==== rtl/wdog_pkg.sv ====
// constants for the watchdog control and status block
package wdog_pkg;
	// bit positions inside the control register
	localparam int unsigned WRITE_EN_POS = 0;
	localparam int unsigned ENABLE_POS = 1;
	localparam int unsigned STATUS_POS = 2;
	localparam int unsigned IRSEL_POS = 3;
	// reset value of the control register
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	// default timeout length in core clock cycles
	localparam int unsigned TIMEOUT_CYCLES_DEFAULT = 65536;
endpackage

// ==== test/core_model.sv ====
// core model issuing control writes and other instructions
`timescale 1ns/1ps
module core_model(input wire logic clk_i,output logic wr_o,output logic [7:0] d_o,output logic done_o);
initial begin wr_o=0; d_o=0; done_o=0; end
// one instruction per call; released data inverts so stale values never look valid
task op(input logic w,input logic [7:0] d);
@(negedge clk_i); wr_o<=w; done_o<=!w; d_o<=d;
@(negedge clk_i); wr_o<=0; done_o<=0; d_o<=~d;
endtask
endmodule

// ==== test/test_watchdog_control_status.sv ====
// testbench for the watchdog control and status block
`timescale 1ns/1ps
module test_watchdog_control_status;
logic clk_i=0,sys_rst_i=1,supply_monitor_irq_i=0,reg_wr_i,instr_done_i,wdog_reset_o,wdog_irq_o;
logic [7:0] reg_wdata_i,reg_rdata_o;
int mismatches=0,check_count=0;
always #4 clk_i=~clk_i;
core_model core_model_inst(.clk_i(clk_i),.wr_o(reg_wr_i),.d_o(reg_wdata_i),.done_o(instr_done_i));
watchdog_control_status #(.TIMEOUT_CYCLES(16)) watchdog_control_status_inst(.clk_i(clk_i),.sys_rst_i(sys_rst_i),
.reg_wr_i(reg_wr_i),.reg_wdata_i(reg_wdata_i),.instr_done_i(instr_done_i),.reg_rdata_o(reg_rdata_o),
.supply_monitor_irq_i(supply_monitor_irq_i),.wdog_reset_o(wdog_reset_o),.wdog_irq_o(wdog_irq_o));
task cmp(input string n,input logic [7:0] e,input logic [7:0] s);
check_count++;
if(s!==e) begin mismatches++; $display("[FAIL] %s exp %h got %h",n,e,s); end
endtask
task results;
$display("checks %0d mismatches %0d",check_count,mismatches);
if(mismatches==0&&check_count>0) $display("SIMULATION PASSED"); else $display("SIMULATION FAILED");
$finish;
endtask
// bounded wait for either timeout response
task wait_out; for(int n=0;n<40&&!(wdog_reset_o|wdog_irq_o);n++) begin @(posedge clk_i); #1; end endtask
task t_protect; core_model_inst.op(1,8'h02); cmp("no arm",8'h00,reg_rdata_o);
core_model_inst.op(1,8'h01); core_model_inst.op(0,8'h00); core_model_inst.op(1,8'h0a);
cmp("disarmed",8'h00,reg_rdata_o); endtask
task t_reset; core_model_inst.op(1,8'h01); core_model_inst.op(1,8'h02); wait_out;
cmp("rst pulse",8'h01,{6'h0,wdog_irq_o,wdog_reset_o}); cmp("rst reg",8'h04,reg_rdata_o);
core_model_inst.op(0,8'h00); cmp("hold",8'h04,reg_rdata_o);
core_model_inst.op(1,8'h01); core_model_inst.op(1,8'h00); cmp("clear",8'h00,reg_rdata_o); endtask
task t_irq; core_model_inst.op(1,8'h01); core_model_inst.op(1,8'h0a); wait_out;
cmp("irq pulse",8'h02,{6'h0,wdog_irq_o,wdog_reset_o}); cmp("irq reg",8'h0e,reg_rdata_o);
@(negedge clk_i) supply_monitor_irq_i<=1; @(negedge clk_i) supply_monitor_irq_i<=0;
cmp("supply",8'h0c,reg_rdata_o); endtask
task t_hw_reset; @(negedge clk_i) sys_rst_i<=1; repeat(2) @(negedge clk_i); sys_rst_i<=0;
@(negedge clk_i); cmp("hw reset",8'h00,reg_rdata_o); endtask
initial begin repeat(12) @(negedge clk_i); sys_rst_i<=0; t_protect; t_reset; t_irq; t_hw_reset; results; end
initial begin #20000; mismatches++; results; end
endmodule

// ==== test/wdog_chk.sv ====
// port checker for the watchdog block
`timescale 1ns/1ps
module wdog_chk(input wire logic clk_i,input wire logic sys_rst_i,input wire logic reg_wr_i,
input wire logic [7:0] reg_wdata_i,input wire logic instr_done_i,input wire logic supply_monitor_irq_i,
input wire logic [7:0] reg_rdata_o,input wire logic wdog_reset_o,input wire logic wdog_irq_o);
default clocking @(posedge clk_i); endclocking
default disable iff (sys_rst_i);
wire logic [7:0] r = reg_rdata_o; // short alias keeps lines narrow
chk_status_set: assert property ((wdog_reset_o|wdog_irq_o) |-> ##[0:1] r[2]) else $error("status not set");
chk_status_hold: assert property (r[2] && !reg_wr_i |=> r[2]) else $error("status lost");
chk_quiet_after_en: assert property ($rose(r[1]) |-> !(wdog_reset_o|wdog_irq_o)[*8]) else $error("early");
chk_reset_clears_en: assert property (wdog_reset_o |-> ##[0:1] !r[1]) else $error("enable kept");
chk_supply_clears: assert property (supply_monitor_irq_i |=> !r[1]) else $error("supply ignored");
chk_irq_keeps_en: assert property (wdog_irq_o |-> r[1] && r[3]) else $error("irq mode wrong");
chk_write_refused: assert property (reg_wr_i && !r[0] && !reg_wdata_i[0] |=> r[3]==$past(r[3])) else $error("stored");
chk_arm_drop: assert property (r[0] && instr_done_i |=> !r[0]) else $error("still armed");
endmodule
bind watchdog_control_status wdog_chk wdog_chk_inst(.clk_i,.sys_rst_i,.reg_wr_i,.reg_wdata_i,.instr_done_i,
.supply_monitor_irq_i,.reg_rdata_o,.wdog_reset_o,.wdog_irq_o);
